// ### io_port_pkg.sv
/*
 Constants for the two 8-bit I/O ports with alternate functions:
 register offsets, reset values, pin indices and field positions.
 Assumes a 32-bit APB slave with byte addresses and one word per register.
*/
package io_port_pkg;
  localparam int ADDR_W = 8;
  localparam int PINS = 16;

  localparam logic [ADDR_W-1:0] OFF_PA_DATA = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_PA_DIR = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_PA_PULL = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_PA_DIE = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_PB_DATA = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_PB_DIR = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_PB_PULL = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_PB_DIE = 8'h1c;
  localparam logic [ADDR_W-1:0] OFF_PA_IN = 8'h20;
  localparam logic [ADDR_W-1:0] OFF_PB_IN = 8'h24;
  localparam logic [ADDR_W-1:0] OFF_IRQ_CFG = 8'h28;
  localparam logic [ADDR_W-1:0] OFF_ALT_SEL = 8'h2c;
  localparam logic [ADDR_W-1:0] OFF_WAKE_FAST = 8'h30;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 8'h34;
  localparam logic [ADDR_W-1:0] OFF_IRQ_CLR = 8'h38;
  localparam logic [ADDR_W-1:0] OFF_IRQ_EN = 8'h3c;

  localparam logic [15:0] RST_DIE = 16'hffff;
  localparam logic [15:0] RST_ZERO16 = 16'h0000;
  localparam logic [5:0] RST_CFG = 6'h00;
  localparam logic [2:0] RST_IRQ = 3'h0;

  // Pin indices: port A in 7..0, port B in 15..8
  localparam int PA0 = 0;
  localparam int PA3 = 3;
  localparam int PA4 = 4;
  localparam int PA5 = 5;
  localparam int PA6 = 6;
  localparam int PA7 = 7;
  localparam int PB0 = 8;
  localparam int PB1 = 9;
  localparam int PB2 = 10;
  localparam int PB3 = 11;
  localparam int PB4 = 12;
  localparam int PB5 = 13;
  localparam int PB6 = 14;
  localparam int PB7 = 15;

  // Alternate select bits
  localparam int AS_G0_PA0 = 0;
  localparam int AS_G0_PB5 = 1;
  localparam int AS_G0_PB4 = 2;
  localparam int AS_G1_PA4 = 3;
  localparam int AS_G1_PB7 = 4;
  localparam int AS_G1_PB6 = 5;
  localparam int AS_G2_PA5 = 6;
  localparam int AS_G2_PA3 = 7;
  localparam int AS_G2_PB3 = 8;
  localparam int AS_G2_PB2 = 9;
  localparam int AS_TB_PA3 = 10;
  localparam int AS_TB_PB4 = 11;
  localparam int AS_TB_PB2 = 12;
  localparam int AS_CMP_PA0 = 13;
  localparam int AS_XTAL = 14;
  localparam int AS_HWRST = 15;

  // Interrupt configuration bits
  localparam int CF_EXT_IRQ_ZERO_ALT = 0;
  localparam int CF_EXT_IRQ_ONE_ALT = 1;
  localparam int CF_EXT_IRQ_ZERO_EDGE = 2;
  localparam int CF_EXT_IRQ_ONE_EDGE = 4;

  localparam logic [1:0] EDGE_RISE = 2'h0;
  localparam logic [1:0] EDGE_FALL = 2'h1;

  // Status bits
  localparam int ST_EXT_IRQ_ZERO = 0;
  localparam int ST_EXT_IRQ_ONE = 1;
  localparam int ST_WAKE = 2;
endpackage

// ### pin_sync.sv
/*
 Two-flip-flop synchroniser for the sixteen pin inputs.
 Assumes the inputs are asynchronous to REF_CLK_I.
*/
module pin_sync
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [io_port_pkg::PINS-1:0] d_i,
  output logic [io_port_pkg::PINS-1:0] q_o
);
  import io_port_pkg::*;
  logic [PINS-1:0] meta_ff;
  logic [PINS-1:0] q_ff;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_ff <= RST_ZERO16;
      q_ff <= RST_ZERO16;
    end else begin
      meta_ff <= d_i;
      q_ff <= meta_ff;
    end
  end

  assign q_o = q_ff;
endmodule // pin_sync

// ### io_port_pins.sv
/*
 Two 8-bit I/O ports with pull-ups, digital-input enable, wake-up,
 two external interrupt lines and alternate output routing, on APB.
 Assumes pads resolve output, enable and pull-up; PWM and comparator
 inputs come from logic on REF_CLK_I.
*/
// Chosen here: the placing of the registers and the APB register port.
// Function
// - Each pin is digital input or push-pull output with optional pull-up.
// - Port A bit 5 drives only low, keeps input and pull-up.
// - Clearing input-enable bit blocks input path and wake-up from that pin.
// - External interrupts trigger on a register-selected rising, falling or either edge.
// - Interrupt line zero comes from PA0 or PB5 by configuration.
// - Interrupt line one comes from PB0 or PA4 by configuration.
// - Three PWM generator outputs route to their listed pins.
// - Timer PWM output routes to PA3, PB4 or PB2.
// - Comparator output is an alternate function on PA0.
// - Any pin can wake the device, with normal or fast speed.
module io_port_pins
(
  input wire logic REF_CLK_I,
  input wire logic RESET_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [io_port_pkg::ADDR_W-1:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic [7:0] PA_I,
  output logic [7:0] PA_O,
  output logic [7:0] PA_OE_O,
  output logic [7:0] PA_PU_O,
  input wire logic [7:0] PB_I,
  output logic [7:0] PB_O,
  output logic [7:0] PB_OE_O,
  output logic [7:0] PB_PU_O,
  input wire logic PWM_GEN_ZERO_OUT_I,
  input wire logic PWM_GEN_ONE_OUT_I,
  input wire logic PWM_GEN_TWO_OUT_I,
  input wire logic TIMER_B_PWM_OUT_I,
  input wire logic COMPARATOR_OUT_I,
  output logic CRYSTAL_EN_O,
  output logic HW_RESET_PIN_O,
  output logic EXT_IRQ_ZERO_O,
  output logic EXT_IRQ_ONE_O,
  output logic WAKE_O,
  output logic WAKE_FAST_O,
  output logic IRQ_O
);
  import io_port_pkg::*;

  function automatic logic [15:0] wr_byte(input logic [15:0] old, input logic hi, input logic [7:0] val);
    wr_byte = hi ? {val, old[7:0]} : {old[15:8], val};
  endfunction
  function automatic logic edge_hit(input logic [1:0] mode, input logic prev, input logic cur);
    if (mode == EDGE_RISE) begin
      edge_hit = cur & ~prev;
    end else if (mode == EDGE_FALL) begin
      edge_hit = prev & ~cur;
    end else begin
      edge_hit = cur ^ prev;
    end
  endfunction
  logic [15:0] data_ff, dir_ff, pull_ff, die_ff, fast_ff, alt_ff;
  logic [15:0] nxt_data, nxt_dir, nxt_pull, nxt_die, nxt_fast, nxt_alt;
  logic [5:0] cfg_ff, nxt_cfg;
  logic [2:0] stat_ff, nxt_stat, en_ff, nxt_en;
  logic [31:0] rdata_ff, nxt_rdata;
  logic slverr_ff, nxt_slverr;
  logic [15:0] sync_q, sync_prev_ff, pin_in, changed;
  logic [15:0] out_ff, nxt_out, oe_ff, nxt_oe, pu_ff, nxt_pu;
  logic [15:0] alt_en, alt_val;
  logic irq0_ff, irq1_ff, wake_ff, fast_wake_ff, hwrst_ff;
  logic nxt_irq0, nxt_irq1, nxt_wake, nxt_fast_wake, nxt_hwrst;
  logic src0_cur, src0_prev, src1_cur, src1_prev;
  logic wr_en, rd_setup, hit;
  pin_sync u_sync (
    .clk_i(REF_CLK_I),
    .rst_i(RESET_I),
    .d_i({PB_I, PA_I}),
    .q_o(sync_q)
  );
  assign pin_in = sync_q & die_ff;
  assign changed = (sync_q ^ sync_prev_ff) & die_ff;
  assign src0_cur = cfg_ff[CF_EXT_IRQ_ZERO_ALT] ? pin_in[PB5] : pin_in[PA0];
  assign src0_prev = cfg_ff[CF_EXT_IRQ_ZERO_ALT] ? (sync_prev_ff[PB5] & die_ff[PB5]) : (sync_prev_ff[PA0] & die_ff[PA0]);
  assign src1_cur = cfg_ff[CF_EXT_IRQ_ONE_ALT] ? pin_in[PA4] : pin_in[PB0];
  assign src1_prev = cfg_ff[CF_EXT_IRQ_ONE_ALT] ? (sync_prev_ff[PA4] & die_ff[PA4]) : (sync_prev_ff[PB0] & die_ff[PB0]);
  assign wr_en = PSEL_I & PENABLE_I & PWRITE_I;
  assign rd_setup = PSEL_I & ~PENABLE_I;
  // Alternate output selection, later assignments win
  always_comb begin
    alt_en = RST_ZERO16;
    alt_val = RST_ZERO16;
    if (alt_ff[AS_TB_PA3]) begin alt_en[PA3] = 1'b1; alt_val[PA3] = TIMER_B_PWM_OUT_I; end
    if (alt_ff[AS_TB_PB4]) begin alt_en[PB4] = 1'b1; alt_val[PB4] = TIMER_B_PWM_OUT_I; end
    if (alt_ff[AS_TB_PB2]) begin alt_en[PB2] = 1'b1; alt_val[PB2] = TIMER_B_PWM_OUT_I; end
    if (alt_ff[AS_G0_PA0]) begin alt_en[PA0] = 1'b1; alt_val[PA0] = PWM_GEN_ZERO_OUT_I; end
    if (alt_ff[AS_G0_PB5]) begin alt_en[PB5] = 1'b1; alt_val[PB5] = PWM_GEN_ZERO_OUT_I; end
    if (alt_ff[AS_G0_PB4]) begin alt_en[PB4] = 1'b1; alt_val[PB4] = PWM_GEN_ZERO_OUT_I; end
    if (alt_ff[AS_G1_PA4]) begin alt_en[PA4] = 1'b1; alt_val[PA4] = PWM_GEN_ONE_OUT_I; end
    if (alt_ff[AS_G1_PB7]) begin alt_en[PB7] = 1'b1; alt_val[PB7] = PWM_GEN_ONE_OUT_I; end
    if (alt_ff[AS_G1_PB6]) begin alt_en[PB6] = 1'b1; alt_val[PB6] = PWM_GEN_ONE_OUT_I; end
    if (alt_ff[AS_G2_PA5]) begin alt_en[PA5] = 1'b1; alt_val[PA5] = PWM_GEN_TWO_OUT_I; end
    if (alt_ff[AS_G2_PA3]) begin alt_en[PA3] = 1'b1; alt_val[PA3] = PWM_GEN_TWO_OUT_I; end
    if (alt_ff[AS_G2_PB3]) begin alt_en[PB3] = 1'b1; alt_val[PB3] = PWM_GEN_TWO_OUT_I; end
    if (alt_ff[AS_G2_PB2]) begin alt_en[PB2] = 1'b1; alt_val[PB2] = PWM_GEN_TWO_OUT_I; end
    if (alt_ff[AS_CMP_PA0]) begin alt_en[PA0] = 1'b1; alt_val[PA0] = COMPARATOR_OUT_I; end
  end

  // Pad drive, events and register file next values
  always_comb begin
    logic [7:0] wb;
    logic drv;
    wb = PWDATA_I[7:0];
    drv = 1'b0;
    for (int i = 0; i < PINS; i++) begin
      nxt_out[i] = alt_en[i] ? alt_val[i] : data_ff[i];
      nxt_oe[i] = alt_en[i] | dir_ff[i];
    end
    nxt_pu = pull_ff;
    drv = nxt_out[PA5];
    nxt_out[PA5] = 1'b0;
    nxt_oe[PA5] = nxt_oe[PA5] & ~drv & ~alt_ff[AS_HWRST];
    if (alt_ff[AS_XTAL]) begin
      nxt_oe[PA7] = 1'b0;
      nxt_oe[PA6] = 1'b0;
      nxt_pu[PA7] = 1'b0;
      nxt_pu[PA6] = 1'b0;
    end
    nxt_irq0 = edge_hit(cfg_ff[CF_EXT_IRQ_ZERO_EDGE +: 2], src0_prev, src0_cur);
    nxt_irq1 = edge_hit(cfg_ff[CF_EXT_IRQ_ONE_EDGE +: 2], src1_prev, src1_cur);
    nxt_wake = |changed;
    nxt_fast_wake = |(changed & fast_ff);
    nxt_hwrst = alt_ff[AS_HWRST] & ~sync_q[PA5];
    nxt_data = data_ff;
    nxt_dir = dir_ff;
    nxt_pull = pull_ff;
    nxt_die = die_ff;
    nxt_fast = fast_ff;
    nxt_alt = alt_ff;
    nxt_cfg = cfg_ff;
    nxt_en = en_ff;
    nxt_stat = stat_ff;
    if (wr_en) begin
      if (PADDR_I == OFF_PA_DATA || PADDR_I == OFF_PB_DATA) begin
        nxt_data = wr_byte(data_ff, PADDR_I[4], wb);
      end else if (PADDR_I == OFF_PA_DIR || PADDR_I == OFF_PB_DIR) begin
        nxt_dir = wr_byte(dir_ff, PADDR_I[4], wb);
      end else if (PADDR_I == OFF_PA_PULL || PADDR_I == OFF_PB_PULL) begin
        nxt_pull = wr_byte(pull_ff, PADDR_I[4], wb);
      end else if (PADDR_I == OFF_PA_DIE || PADDR_I == OFF_PB_DIE) begin
        nxt_die = wr_byte(die_ff, PADDR_I[4], wb);
      end else if (PADDR_I == OFF_IRQ_CFG) begin
        nxt_cfg = PWDATA_I[5:0];
      end else if (PADDR_I == OFF_ALT_SEL) begin
        nxt_alt = PWDATA_I[15:0];
      end else if (PADDR_I == OFF_WAKE_FAST) begin
        nxt_fast = PWDATA_I[15:0];
      end else if (PADDR_I == OFF_IRQ_CLR) begin
        nxt_stat = stat_ff & ~PWDATA_I[2:0];
      end else if (PADDR_I == OFF_IRQ_EN) begin
        nxt_en = PWDATA_I[2:0];
      end
    end
    // Set wins over clear
    nxt_stat = nxt_stat | {nxt_wake, nxt_irq1, nxt_irq0};
    hit = 1'b1;
    nxt_rdata = rdata_ff;
    nxt_slverr = slverr_ff;
    if (PADDR_I == OFF_PA_DATA || PADDR_I == OFF_PB_DATA) begin
      nxt_rdata = {24'h000000, PADDR_I[4] ? data_ff[15:8] : data_ff[7:0]};
    end else if (PADDR_I == OFF_PA_DIR || PADDR_I == OFF_PB_DIR) begin
      nxt_rdata = {24'h000000, PADDR_I[4] ? dir_ff[15:8] : dir_ff[7:0]};
    end else if (PADDR_I == OFF_PA_PULL || PADDR_I == OFF_PB_PULL) begin
      nxt_rdata = {24'h000000, PADDR_I[4] ? pull_ff[15:8] : pull_ff[7:0]};
    end else if (PADDR_I == OFF_PA_DIE || PADDR_I == OFF_PB_DIE) begin
      nxt_rdata = {24'h000000, PADDR_I[4] ? die_ff[15:8] : die_ff[7:0]};
    end else if (PADDR_I == OFF_PA_IN) begin
      nxt_rdata = {24'h000000, pin_in[7:0]};
    end else if (PADDR_I == OFF_PB_IN) begin
      nxt_rdata = {24'h000000, pin_in[15:8]};
    end else if (PADDR_I == OFF_IRQ_CFG) begin
      nxt_rdata = {26'h0000000, cfg_ff};
    end else if (PADDR_I == OFF_ALT_SEL) begin
      nxt_rdata = {16'h0000, alt_ff};
    end else if (PADDR_I == OFF_WAKE_FAST) begin
      nxt_rdata = {16'h0000, fast_ff};
    end else if (PADDR_I == OFF_IRQ_STAT) begin
      nxt_rdata = {29'h00000000, stat_ff};
    end else if (PADDR_I == OFF_IRQ_CLR) begin
      nxt_rdata = 32'h00000000;
    end else if (PADDR_I == OFF_IRQ_EN) begin
      nxt_rdata = {29'h00000000, en_ff};
    end else begin
      nxt_rdata = 32'h00000000;
      hit = 1'b0;
    end
    if (rd_setup) begin
      nxt_slverr = ~hit;
    end else begin
      nxt_rdata = rdata_ff;
    end
  end

  always_ff @(posedge REF_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      data_ff <= RST_ZERO16;
      dir_ff <= RST_ZERO16;
      pull_ff <= RST_ZERO16;
      die_ff <= RST_DIE;
      fast_ff <= RST_ZERO16;
      alt_ff <= RST_ZERO16;
      cfg_ff <= RST_CFG;
      stat_ff <= RST_IRQ;
      en_ff <= RST_IRQ;
      rdata_ff <= 32'h00000000;
      slverr_ff <= 1'b0;
      sync_prev_ff <= RST_ZERO16;
      out_ff <= RST_ZERO16;
      oe_ff <= RST_ZERO16;
      pu_ff <= RST_ZERO16;
      irq0_ff <= 1'b0;
      irq1_ff <= 1'b0;
      wake_ff <= 1'b0;
      fast_wake_ff <= 1'b0;
      hwrst_ff <= 1'b0;
    end else begin
      data_ff <= nxt_data;
      dir_ff <= nxt_dir;
      pull_ff <= nxt_pull;
      die_ff <= nxt_die;
      fast_ff <= nxt_fast;
      alt_ff <= nxt_alt;
      cfg_ff <= nxt_cfg;
      stat_ff <= nxt_stat;
      en_ff <= nxt_en;
      rdata_ff <= nxt_rdata;
      slverr_ff <= nxt_slverr;
      sync_prev_ff <= sync_q;
      out_ff <= nxt_out;
      oe_ff <= nxt_oe;
      pu_ff <= nxt_pu;
      irq0_ff <= nxt_irq0;
      irq1_ff <= nxt_irq1;
      wake_ff <= nxt_wake;
      fast_wake_ff <= nxt_fast_wake;
      hwrst_ff <= nxt_hwrst;
    end
  end

  assign PRDATA_O = rdata_ff;
  assign PREADY_O = 1'b1;
  assign PSLVERR_O = PSEL_I & PENABLE_I & slverr_ff;
  assign PA_O = out_ff[7:0];
  assign PB_O = out_ff[15:8];
  assign PA_OE_O = oe_ff[7:0];
  assign PB_OE_O = oe_ff[15:8];
  assign PA_PU_O = pu_ff[7:0];
  assign PB_PU_O = pu_ff[15:8];
  assign CRYSTAL_EN_O = alt_ff[AS_XTAL];
  assign HW_RESET_PIN_O = hwrst_ff;
  assign EXT_IRQ_ZERO_O = irq0_ff;
  assign EXT_IRQ_ONE_O = irq1_ff;
  assign WAKE_O = wake_ff;
  assign WAKE_FAST_O = fast_wake_ff;
  assign IRQ_O = |(stat_ff & en_ff);

  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (RESET_I);

  sequence s_fall0;
    cfg_ff[CF_EXT_IRQ_ZERO_EDGE +: 2] == EDGE_FALL && src0_prev && !src0_cur;
  endsequence
  sequence s_rise0_alt;
    cfg_ff[CF_EXT_IRQ_ZERO_ALT] && cfg_ff[CF_EXT_IRQ_ZERO_EDGE +: 2] == EDGE_RISE && pin_in[PB5] && !sync_prev_ff[PB5];
  endsequence

  property p_od;
    (dir_ff[PA5] && !alt_ff[AS_G2_PA5] && !alt_ff[AS_HWRST])
      |=> !PA_O[PA5] && PA_OE_O[PA5] == !$past(data_ff[PA5]);
  endproperty
  a_od: assert property (p_od) else $error("open-drain pin drove high");
  property p_push;
    (dir_ff[PB1] && !alt_ff[AS_XTAL]) |=> (PB_OE_O[PB1 - 8] && PB_O[PB1 - 8] == $past(data_ff[PB1]));
  endproperty
  a_push: assert property (p_push) else $error("output pin not driving port data");
  property p_die_wake;
    WAKE_O |-> (($past(sync_q ^ sync_prev_ff) & $past(die_ff)) != 16'h0000);
  endproperty
  a_die_wake: assert property (p_die_wake) else $error("wake from a disabled pin");
  property p_fall0;
    s_fall0 |=> EXT_IRQ_ZERO_O ##0 stat_ff[ST_EXT_IRQ_ZERO];
  endproperty
  a_fall0: assert property (p_fall0) else $error("falling edge missed on line zero");
  property p_src0_alt;
    s_rise0_alt |=> EXT_IRQ_ZERO_O;
  endproperty
  a_src0_alt: assert property (p_src0_alt) else $error("alternate line zero source ignored");
  property p_src1_alt;
    (cfg_ff[CF_EXT_IRQ_ONE_ALT] && cfg_ff[CF_EXT_IRQ_ONE_EDGE +: 2] == EDGE_RISE && pin_in[PA4] && !sync_prev_ff[PA4])
      |=> EXT_IRQ_ONE_O;
  endproperty
  a_src1_alt: assert property (p_src1_alt) else $error("alternate line one source ignored");
  property p_gen0;
    (alt_ff[AS_G0_PA0] && !alt_ff[AS_CMP_PA0]) |=> (PA_OE_O[PA0] && PA_O[PA0] == $past(PWM_GEN_ZERO_OUT_I));
  endproperty
  a_gen0: assert property (p_gen0) else $error("generator zero not on PA0");
  property p_timer;
    (alt_ff[AS_TB_PB2] && !alt_ff[AS_G2_PB2]) |=> PB_O[PB2 - 8] == $past(TIMER_B_PWM_OUT_I);
  endproperty
  a_timer: assert property (p_timer) else $error("timer output not on PB2");
  property p_cmp;
    alt_ff[AS_CMP_PA0] |=> PA_O[PA0] == $past(COMPARATOR_OUT_I);
  endproperty
  a_cmp: assert property (p_cmp) else $error("comparator output not on PA0");
  property p_fast;
    WAKE_FAST_O |-> WAKE_O && stat_ff[ST_WAKE];
  endproperty
  a_fast: assert property (p_fast) else $error("fast wake without wake event");
  property p_port_own;
    (alt_ff[AS_G0_PA0] == 1'b0 && alt_ff[AS_CMP_PA0] == 1'b0) |=> PA_O[PA0] == $past(data_ff[PA0]);
  endproperty
  a_port_own: assert property (p_port_own) else $error("port data lost without alternate");
endmodule // io_port_pins

// ### pin_loads.sv
/*
 Far side of the two ports: pads, pull-ups and outside drivers.
 Assumes the bench drives ext_val_i and ext_drv_i on clock edges.
*/
module pin_loads (
  input wire logic clk_i,
  input wire logic [15:0] out_i,
  input wire logic [15:0] oe_i,
  input wire logic [15:0] pu_i,
  input wire logic [15:0] ext_val_i,
  input wire logic [15:0] ext_drv_i,
  output logic [15:0] lvl_o
);
  logic [15:0] last_ff;

  always_comb begin
    for (int i = 0; i < 16; i++) begin
      if (oe_i[i]) begin
        lvl_o[i] = out_i[i];
      end else if (ext_drv_i[i]) begin
        lvl_o[i] = ext_val_i[i];
      end else if (pu_i[i]) begin
        lvl_o[i] = 1'b1;
      end else begin
        lvl_o[i] = ~last_ff[i];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    last_ff <= lvl_o;
  end
endmodule // pin_loads

// ### io_port_pins_bench.sv
/*
 Self-checking bench of the I/O port block over APB.
 Assumes pin_loads stands for the pads and outside drivers.
*/
module io_port_pins_bench
  import io_port_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, er;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd, cfg;
  logic [7:0] pa_o, pa_oe, pa_pu, pb_o, pb_oe, pb_pu;
  logic [15:0] lvl, ext_val, ext_drv, po, poe;
  logic [4:0] src;
  logic [3:0] s;
  logic xtal, irq0, irq1, wake, wfast, irq, hwrst;
  int failures, num_checks, pin, ln;
  int pin_of[14] = '{PA0, PB5, PB4, PA4, PB7, PB6, PA5, PA3, PB3, PB2, PA3, PB4, PB2, PA0};
  int src_of[14] = '{0, 0, 0, 1, 1, 1, 2, 2, 2, 2, 3, 3, 3, 4};
  assign po = {pb_o, pa_o};
  assign poe = {pb_oe, pa_oe};

  io_port_pins uut (.REF_CLK_I(clk), .RESET_I(rst), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .PA_I(lvl[7:0]), .PA_O(pa_o), .PA_OE_O(pa_oe), .PA_PU_O(pa_pu),
    .PB_I(lvl[15:8]), .PB_O(pb_o), .PB_OE_O(pb_oe), .PB_PU_O(pb_pu), .PWM_GEN_ZERO_OUT_I(src[0]),
    .PWM_GEN_ONE_OUT_I(src[1]), .PWM_GEN_TWO_OUT_I(src[2]), .TIMER_B_PWM_OUT_I(src[3]),
    .COMPARATOR_OUT_I(src[4]), .CRYSTAL_EN_O(xtal), .HW_RESET_PIN_O(hwrst), .EXT_IRQ_ZERO_O(irq0),
    .EXT_IRQ_ONE_O(irq1), .WAKE_O(wake), .WAKE_FAST_O(wfast), .IRQ_O(irq));

  pin_loads loads (.clk_i(clk), .out_i(po), .oe_i(poe), .pu_i({pb_pu, pa_pu}),
    .ext_val_i(ext_val), .ext_drv_i(ext_drv), .lvl_o(lvl));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic test_done();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      failures++;
      test_done();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Collects pulses seen over a window
  task automatic watch(input int n);
    s = 4'h0;
    repeat (n) begin
      @(posedge clk);
      s = s | {wfast, wake, irq1, irq0};
    end
  endtask

  initial begin
    repeat (50000) @(posedge clk);
    failures++;
    test_done();
  end

  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    src = 5'h00;
    ext_val = 16'h0000;
    ext_drv = 16'hffff;
    failures = 0;
    num_checks = 0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, OFF_PA_DIE, 32'h0);
    check(rd, 32'hff, "input enable reset"); // input path open
    check(poe, 16'h0, "oe at reset"); // pins start as inputs
    apb(1'b1, OFF_PA_DIR, 32'hff);
    apb(1'b1, OFF_PA_DATA, 32'h5a);
    apb(1'b1, OFF_PA_PULL, 32'h0f);
    apb(1'b1, OFF_PB_DIR, 32'hff);
    apb(1'b1, OFF_PB_DATA, 32'h3c);
    tick(2);
    check({pa_oe, pa_o, pa_pu}, 32'hff5a0f, "port a out"); // push-pull
    check({pb_oe, pb_o}, 32'hff3c, "port b out"); // push-pull
    apb(1'b1, OFF_PA_DATA, 32'hff);
    tick(2);
    check({pa_oe, pa_o}, 32'hdfdf, "open drain"); // bit 5 low only
    apb(1'b1, OFF_PA_DIR, 32'h0);
    apb(1'b1, OFF_PB_DIR, 32'h0);
    ext_val <= 16'h00ff;
    tick(4);
    apb(1'b0, OFF_PA_IN, 32'h0);
    check(rd, 32'hff, "pin input"); // digital input
    apb(1'b1, OFF_PA_DIE, 32'he7); // analog inputs released
    apb(1'b0, OFF_PA_IN, 32'h0);
    check(rd, 32'he7, "gated input"); // input blocked
    apb(1'b1, OFF_PA_DIE, 32'hff);
    for (int k = 0; k < 8; k++) begin
      ln = k / 4;
      pin = (ln == 0) ? (k[1] ? PB5 : PA0) : (k[1] ? PA4 : PB0);
      cfg = (32'(k[1]) << (ln == 0 ? CF_EXT_IRQ_ZERO_ALT : CF_EXT_IRQ_ONE_ALT))
        | (32'(k[0] ? EDGE_FALL : EDGE_RISE) << (ln == 0 ? CF_EXT_IRQ_ZERO_EDGE : CF_EXT_IRQ_ONE_EDGE));
      apb(1'b1, OFF_IRQ_CFG, cfg);
      ext_val[pin] <= k[0];
      tick(6);
      apb(1'b1, OFF_IRQ_CLR, 32'h7);
      ext_val[pin] <= ~k[0];
      watch(8);
      check(s[ln], 1'b1, "irq edge"); // selected edge
      apb(1'b0, OFF_IRQ_STAT, 32'h0);
      check(rd[ln], 1'b1, "irq status"); // source select
      ext_val[pin] <= k[0];
      watch(8);
      check(s[ln], 1'b0, "other edge"); // opposite edge ignored
    end
    apb(1'b1, OFF_IRQ_CFG, (32'h1 << CF_EXT_IRQ_ONE_ALT) | (32'h2 << CF_EXT_IRQ_ONE_EDGE));
    ext_val[PA4] <= 1'b0;
    watch(8);
    check(s[1], 1'b1, "both edges fall"); // either edge in both mode
    ext_val[PA4] <= 1'b1;
    watch(8);
    check(s[1], 1'b1, "both edges rise"); // either edge in both mode
    apb(1'b1, OFF_IRQ_EN, 32'h0);
    tick(1);
    check(irq, 1'b0, "irq masked"); // wake status masked
    apb(1'b1, OFF_IRQ_EN, 32'h1 << ST_WAKE);
    tick(1);
    check(irq, 1'b1, "irq enabled"); // wake status raises line
    apb(1'b1, OFF_IRQ_CLR, 32'h7);
    tick(1);
    check(irq, 1'b0, "irq cleared"); // wake status cleared
    apb(1'b0, OFF_IRQ_STAT, 32'h0);
    check(rd, 32'h0, "status cleared"); // wake status cleared
    apb(1'b1, OFF_WAKE_FAST, 32'h1 << PB1);
    ext_val[PB1] <= 1'b1;
    watch(8);
    check(s[3:2], 2'b11, "fast wake"); // wake speed
    ext_val[PB2] <= 1'b1;
    watch(8);
    check(s[3:2], 2'b01, "normal wake"); // wake speed
    apb(1'b1, OFF_PB_DIE, 32'hfd);
    ext_val[PB1] <= 1'b0;
    watch(8);
    check(s[3:2], 2'b00, "gated wake"); // wake blocked
    apb(1'b1, OFF_PB_PULL, 32'hff);
    ext_drv[PB7] <= 1'b0;
    tick(4);
    apb(1'b0, OFF_PB_IN, 32'h0);
    check(rd, 32'ha5, "pulled input"); // pull-up holds released pin
    for (int i = 0; i < 14; i++) begin
      pin = pin_of[i];
      src <= 5'h1 << src_of[i];
      apb(1'b1, OFF_ALT_SEL, 32'h1 << i);
      tick(2);
      check({po[pin], poe[pin]}, {pin != PA5, pin != PA5}, "alt high"); // routing
      src <= ~(5'h1 << src_of[i]);
      tick(2);
      check({po[pin], poe[pin]}, 2'b01, "alt low"); // routing
    end
    apb(1'b1, OFF_PA_DIE, 32'h3f); // crystal pins released
    apb(1'b1, OFF_PA_DIR, 32'hc0);
    apb(1'b1, OFF_PA_PULL, 32'hc0);
    apb(1'b1, OFF_ALT_SEL, 32'h1 << AS_XTAL);
    tick(2);
    check({xtal, pa_oe[7:6], pa_pu[7:6]}, 5'b10000, "crystal pins"); // crystal use
    apb(1'b1, OFF_ALT_SEL, 32'h1 << AS_HWRST);
    ext_val[PA5] <= 1'b0;
    tick(4);
    check({hwrst, pa_oe[PA5]}, 2'b10, "reset pin low"); // PA5 as reset input
    ext_val[PA5] <= 1'b1;
    tick(4);
    check(hwrst, 1'b0, "reset pin high"); // PA5 as reset input
    apb(1'b0, 8'h40, 32'h0);
    check(rd, 32'h0, "unmapped data");
    check(er, 1'b1, "unmapped error");
    test_done();
  end
endmodule // io_port_pins_bench
